// *** ovf_fault_latch_ctrl.sv ***
// Overvoltage detection and per-class latching / hiccup restart control.
// Assumes comparator and sensing inputs are asynchronous levels; one 100 MHz clock.
//
// What this block does
// - Overvoltage detection armed only while output is above start-up prebias.
// - Overvoltage trip raises error, turns converter off, clears status bit.
// - On overvoltage, high side off and low side on in same cycle.
// - Threshold is 110 to 130 percent of setpoint, never below 0.5V.
// - Threshold at least 0.25V above setpoint, unless setpoint plus 0.25V overflows 16 bits.
// - Each protection class separately latching or not; propagation held elsewhere.
// - Non-latching trip retries start every 130ms until cause clears.
// - Restart ramps through the normal tracking and sequencing turn-on.
// - Latching trip stays off with no automatic restarts.
// - Latched restart only after 130ms, cause gone, and status clear or on-cycle.
// - Config bits 5..0 hold latch selects: track,temp,current,under,over,phase.
// - Limits recomputed as same percentage when setpoint moves to margin.
// - Tracking faults suppressed during ramp when tracking detection disabled.
// - Level code 00 is 110, 01 is 120, 10 and 11 are 130 percent.
`timescale 1ns/1ps
module ovf_fault_latch_ctrl
  import ovf_pkg::*;
#(
  parameter int HICCUP_CYC = ovf_pkg::OVF_HICCUP_CYC // Retry spacing in cycles
) (
  input wire logic mclk_i, // 100 MHz clock
  input wire logic sys_rst_i, // Async reset, high
  input wire logic clk_en_i, // Clock enable
  input wire logic cfg_wr_i, // Register write strobe
  input wire logic [7:0] cfg_addr_i, // Register address
  input wire logic [7:0] cfg_wdata_i, // Register write data
  output logic [7:0] cfg_rdata_o, // Register read data
  input wire logic status_clr_i, // Software clears the status bits
  input wire logic turn_on_i, // Turn-on command level
  input wire logic [ovf_pkg::OVF_MV_W-1:0] setpoint_mv_i, // Active setpoint incl. margin
  input wire logic [1:0] overvolt_level_field_i, // Level code from threshold config
  input wire logic [ovf_pkg::OVF_MV_W-1:0] vout_mv_i, // Sensed output (async)
  input wire logic [ovf_pkg::OVF_MV_W-1:0] prebias_mv_i, // Prebias seen at start (async)
  input wire logic [4:0] fault_raw_i, // Async: track,temp,current,under,phase
  input wire logic ramping_i, // Ramp-up in progress (async)
  output logic hs_on_o, // High-side switch on
  output logic ls_on_o, // Low-side switch on
  output logic run_o, // Converter enabled, starts normal ramp
  output logic ov_error_o, // Overvoltage error level
  output logic [ovf_pkg::OVF_NUM_CLASS-1:0] protection_status_o, // 1 = ok, 0 = tripped
  output logic [ovf_pkg::OVF_MV_W-1:0] ov_thresh_mv_o // Active threshold
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ovf_state_e st;
    logic [7:0] cfg;
    logic [OVF_NUM_CLASS-1:0] stat;
    logic [31:0] cnt;
    logic on_prev;
    logic on_cycled;
    logic ov_seen;
    logic hs;
    logic ls;
    logic run;
    logic ov_err;
    logic [OVF_MV_W-1:0] thr;
    logic [7:0] rdata;
  } ovf_state_s;

  ovf_state_s s_q, s_d;

  logic [4:0] flt_s;
  logic ramp_s;
  logic [OVF_MV_W-1:0] vout_s, pre_s, thr_c;
  logic ov_hit, ov_raw;
  logic [OVF_NUM_CLASS-1:0] cause, trip;
  logic latch_any, cause_any;

  ovf_sync #(.W(2*OVF_MV_W + 6)) u_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(clk_en_i),
    .d_i({vout_mv_i, prebias_mv_i, fault_raw_i, ramping_i}),
    .q_o({vout_s, pre_s, flt_s, ramp_s})
  );

  ovf_threshold u_thr (
    .setpoint_mv_i(setpoint_mv_i),
    .overvolt_level_field_i(overvolt_level_field_i),
    .ov_thresh_mv_o(thr_c)
  );

  // ****************************************
  // Fault causes
  // ****************************************
  always_comb begin
    // Compare against the registered threshold so a margin step cannot glitch a trip
    ov_raw = (vout_s > pre_s) && (vout_s > s_q.thr);
    // A synchronised word can be torn for one cycle; two hits in a row filter that
    ov_hit = ov_raw && s_q.ov_seen;
    cause[OVF_TRACK_LATCH_SEL_BIT] = flt_s[4] && ramp_s
      && s_q.cfg[OVF_TRACK_FAULT_ENABLE_BIT];
    cause[OVF_OVERTEMP_LATCH_SEL_BIT] = flt_s[3];
    cause[OVF_OVERCURRENT_LATCH_SEL_BIT] = flt_s[2];
    cause[OVF_UNDERVOLT_LATCH_SEL_BIT] = flt_s[1];
    cause[OVF_OVERVOLT_LATCH_SEL_BIT] = ov_hit;
    cause[OVF_PHASE_VOLT_LATCH_SEL_BIT] = flt_s[0]
      && s_q.cfg[OVF_PHASE_VOLT_ERROR_ENABLE_BIT];
    trip = (s_q.st == OVF_RUN) ? cause : '0;
    latch_any = |(trip & s_q.cfg[OVF_NUM_CLASS-1:0]);
    cause_any = |cause;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.thr = thr_c;
    s_d.on_prev = turn_on_i;
    s_d.ov_seen = ov_raw;
    s_d.rdata = (cfg_addr_i == OVF_FAULT_LATCH_CONFIG_ADDR) ? s_q.cfg : 8'h00;
    if (cfg_wr_i && cfg_addr_i == OVF_FAULT_LATCH_CONFIG_ADDR) begin
      s_d.cfg = cfg_wdata_i;
    end
    if (s_q.on_prev && !turn_on_i) begin
      s_d.on_cycled = 1'b1;
    end
    // Trip wins over a software clear in the same cycle
    if (status_clr_i) begin
      s_d.stat = '1;
    end
    s_d.stat = s_d.stat & ~trip;
    if (s_q.cnt != 32'h0) begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
    unique case (s_q.st)
      OVF_OFF: begin
        s_d.hs = 1'b0;
        s_d.ls = 1'b0;
        s_d.run = 1'b0;
        s_d.ov_err = 1'b0;
        if (turn_on_i && !cause_any) begin
          s_d.st = OVF_RUN;
          s_d.run = 1'b1;
          s_d.hs = 1'b1;
        end
      end
      OVF_RUN: begin
        if (!turn_on_i) begin
          s_d.st = OVF_OFF;
          s_d.run = 1'b0;
          s_d.hs = 1'b0;
        end
        if (|trip) begin
          s_d.run = 1'b0;
          s_d.cnt = 32'(HICCUP_CYC);
          // An on-command drop on the trip edge still counts as a cycle
          s_d.on_cycled = s_q.on_prev && !turn_on_i;
          s_d.st = latch_any ? OVF_LATCH : OVF_WAIT;
          if (trip[OVF_OVERVOLT_LATCH_SEL_BIT]) begin
            s_d.ov_err = 1'b1;
            s_d.hs = 1'b0;
            s_d.ls = 1'b1;
          end else begin
            s_d.hs = 1'b0;
            s_d.ls = 1'b0;
          end
        end
      end
      OVF_WAIT: begin
        if (!turn_on_i) begin
          s_d.st = OVF_OFF;
        end else if (s_q.cnt == 32'h0) begin
          if (!cause_any) begin
            s_d.st = OVF_RUN;
            s_d.run = 1'b1;
            s_d.hs = 1'b1;
            s_d.ls = 1'b0;
            s_d.ov_err = 1'b0;
          end else begin
            s_d.cnt = 32'(HICCUP_CYC);
          end
        end
      end
      OVF_LATCH: begin
        // Stays off; no retry until software or the on-command releases it
        if (s_q.cnt == 32'h0 && !cause_any
            && (status_clr_i || s_q.on_cycled)) begin
          s_d.st = OVF_OFF;
          s_d.ls = 1'b0;
          s_d.ov_err = 1'b0;
          s_d.on_cycled = 1'b0;
        end
      end
      default: begin
        s_d.st = OVF_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q.st <= OVF_OFF;
      s_q.cfg <= OVF_CFG_RESET;
      s_q.stat <= '1;
      s_q.cnt <= 32'h0;
      s_q.on_prev <= 1'b0;
      s_q.on_cycled <= 1'b0;
      s_q.ov_seen <= 1'b0;
      s_q.hs <= 1'b0;
      s_q.ls <= 1'b0;
      s_q.run <= 1'b0;
      s_q.ov_err <= 1'b0;
      s_q.thr <= OVF_MIN_OV_MV;
      s_q.rdata <= 8'h00;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata_o = s_q.rdata;
  assign hs_on_o = s_q.hs;
  assign ls_on_o = s_q.ls;
  assign run_o = s_q.run;
  assign ov_error_o = s_q.ov_err;
  assign protection_status_o = s_q.stat;
  assign ov_thresh_mv_o = s_q.thr;

endmodule : ovf_fault_latch_ctrl

// *** ovf_pkg.sv ***
// Package for the overvoltage protection and fault latch control block.
// Assumes a single 100 MHz controller clock and voltages given as unsigned millivolt codes.
package ovf_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OVF_FAULT_LATCH_CONFIG_ADDR = 8'h00;
  localparam logic [7:0] OVF_CFG_RESET = 8'h43;
  localparam int OVF_TRACK_FAULT_ENABLE_BIT = 7;
  localparam int OVF_PHASE_VOLT_ERROR_ENABLE_BIT = 6;
  localparam int OVF_TRACK_LATCH_SEL_BIT = 5;
  localparam int OVF_OVERTEMP_LATCH_SEL_BIT = 4;
  localparam int OVF_OVERCURRENT_LATCH_SEL_BIT = 3;
  localparam int OVF_UNDERVOLT_LATCH_SEL_BIT = 2;
  localparam int OVF_OVERVOLT_LATCH_SEL_BIT = 1;
  localparam int OVF_PHASE_VOLT_LATCH_SEL_BIT = 0;
  localparam int OVF_NUM_CLASS = 6;

  // ****************************************
  // Overvoltage threshold
  // ****************************************
  localparam int OVF_MV_W = 16;
  localparam logic [1:0] OVF_OV_LVL_110 = 2'h0;
  localparam logic [1:0] OVF_OV_LVL_120 = 2'h1;
  localparam logic [7:0] OVF_PCT_110 = 8'h6e;
  localparam logic [7:0] OVF_PCT_120 = 8'h78;
  localparam logic [7:0] OVF_PCT_130 = 8'h82;
  localparam logic [7:0] OVF_PCT_DIV = 8'h64;
  localparam logic [15:0] OVF_MIN_OV_MV = 16'h01f4;
  localparam logic [15:0] OVF_MIN_MARGIN_MV = 16'h00fa;

  // ****************************************
  // Timing
  // ****************************************
  localparam int OVF_CLK_HZ = 100_000_000;
  localparam int OVF_HICCUP_MS = 130;
  localparam int OVF_HICCUP_CYC = OVF_HICCUP_MS * (OVF_CLK_HZ / 1000);

  typedef enum logic [3:0] {
    OVF_OFF   = 4'b0001,
    OVF_RUN   = 4'b0010,
    OVF_WAIT  = 4'b0100,
    OVF_LATCH = 4'b1000
  } ovf_state_e;

endpackage : ovf_pkg

// *** ovf_threshold.sv ***
// Overvoltage threshold from setpoint and level field, with absolute and margin floors.
// Assumes setpoint in millivolts, combinational result registered by the user.
`timescale 1ns/1ps
module ovf_threshold (
  input wire logic [ovf_pkg::OVF_MV_W-1:0] setpoint_mv_i, // Output setpoint
  input wire logic [1:0] overvolt_level_field_i, // Level code
  output logic [ovf_pkg::OVF_MV_W-1:0] ov_thresh_mv_o // Threshold
);
  import ovf_pkg::*;
  logic [7:0] pct;
  logic [31:0] prod;
  logic [OVF_MV_W-1:0] scaled;
  logic [OVF_MV_W:0] floor_margin;
  logic [OVF_MV_W-1:0] lim;

  always_comb begin
    unique case (overvolt_level_field_i)
      OVF_OV_LVL_110: pct = OVF_PCT_110;
      OVF_OV_LVL_120: pct = OVF_PCT_120;
      default: pct = OVF_PCT_130;
    endcase
    // Product follows the live setpoint, so margining moves the limit too
    prod = 32'(setpoint_mv_i) * 32'(pct) / 32'(OVF_PCT_DIV);
    scaled = (prod > 32'(16'hffff)) ? 16'hffff : prod[OVF_MV_W-1:0];
    floor_margin = {1'b0, setpoint_mv_i} + {1'b0, OVF_MIN_MARGIN_MV};
    lim = scaled;
    if (floor_margin[OVF_MV_W-1:0] > lim && !floor_margin[OVF_MV_W]) begin
      lim = floor_margin[OVF_MV_W-1:0];
    end
    if (lim < OVF_MIN_OV_MV) begin
      lim = OVF_MIN_OV_MV;
    end
    ov_thresh_mv_o = lim;
  end
endmodule : ovf_threshold

// *** ovf_sync.sv ***
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes the enable freezes both stages together.
`timescale 1ns/1ps
module ovf_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i, // Clock
  input wire logic sys_rst_i, // Async reset, high
  input wire logic en_i, // Clock enable
  input wire logic [W-1:0] d_i, // Async input
  output logic [W-1:0] q_o // Synchronised
);
  logic [W-1:0] s1_q;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_q <= '0;
      q_o <= '0;
    end else if (en_i) begin
      s1_q <= d_i;
      q_o <= s1_q;
    end
  end
endmodule : ovf_sync

// *** ovf_fault_latch_ctrl_props.sv ***
// Port assertions for the overvoltage fault latch control.
// Assumes setpoint and level code hold still while the clock enable is low.
`timescale 1ns/1ps
module ovf_fault_latch_ctrl_props #(
  parameter int HICCUP_CYC = 20 // Retry spacing
) (
  input wire logic mclk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic status_clr_i, // Status clear
  input wire logic [15:0] setpoint_mv_i, // Setpoint
  input wire logic [1:0] overvolt_level_field_i, // Level code
  input wire logic [15:0] vout_mv_i, // Output
  input wire logic [15:0] prebias_mv_i, // Prebias
  input wire logic hs_on_o, // High side
  input wire logic ls_on_o, // Low side
  input wire logic run_o, // Run
  input wire logic ov_error_o, // Error
  input wire logic [5:0] protection_status_o, // Status
  input wire logic [15:0] ov_thresh_mv_o // Threshold
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] gap_q;
  logic [5:0] st_q;
  function automatic logic [15:0] thr(logic [15:0] sp, logic [1:0] lv);
    int t;
    t = sp * (lv == 2'h0 ? 8'h6e : (lv == 2'h1 ? 8'h78 : 8'h82)) / 8'h64;
    t = (t < sp + 16'h00fa) ? sp + 16'h00fa : t;
    t = (t < 16'h01f4) ? 16'h01f4 : t;
    return t[15:0];
  endfunction : thr
  // Cycles since the latest trip; saturates so reset never looks like a fresh trip
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_q <= 8'hff;
      st_q <= 6'h3f;
    end else begin
      st_q <= protection_status_o;
      if (|(st_q & ~protection_status_o)) begin
        gap_q <= 8'h01;
      end else if (gap_q != 8'hff) begin
        gap_q <= gap_q + 8'h01;
      end
    end
  end
  a_ov_trip_step: assert property ($rose(ov_error_o) |-> $fell(hs_on_o) && ls_on_o)
    else $error("trip did not swap switches in one step");
  a_ov_status_low: assert property ($rose(ov_error_o) |-> !protection_status_o[1])
    else $error("status bit not cleared on trip");
  a_ls_needs_err: assert property (ls_on_o |-> ov_error_o)
    else $error("low side on without error");
  a_err_keeps_off: assert property (ov_error_o |-> !hs_on_o && !run_o)
    else $error("converter running during error");
  a_thresh_value: assert property (!$past(sys_rst_i) |-> ov_thresh_mv_o ==
    thr($past(setpoint_mv_i), $past(overvolt_level_field_i)))
    else $error("threshold wrong");
  a_prebias_arm: assert property ((vout_mv_i <= prebias_mv_i)[*4] |=> !$rose(ov_error_o))
    else $error("trip below prebias");
  a_retry_gap: assert property ($rose(run_o) |-> gap_q >= HICCUP_CYC - 2)
    else $error("restart too soon after trip");
  a_status_clear: assert property (status_clr_i && !run_o |=> protection_status_o == 6'h3f)
    else $error("status not cleared");
endmodule : ovf_fault_latch_ctrl_props

// *** ovf_stage_model.sv ***
// Power stage and output sense model.
// Assumes the bench gives the regulated level and an optional forced level.
`timescale 1ns/1ps
module ovf_stage_model (
  input wire logic mclk_i, // Clock
  input wire logic hs_on_i, // High side on
  input wire logic ls_on_i, // Low side on
  input wire logic [15:0] set_mv_i, // Regulated level
  input wire logic [15:0] force_mv_i, // Forced level, 0 for none
  output logic [15:0] vout_mv_o = 16'h0000 // Sensed output
);
  // Crude on purpose: low side empties the filter at once
  always_ff @(posedge mclk_i) begin
    if (ls_on_i) begin
      vout_mv_o <= 16'h0000;
    end else if (force_mv_i != 16'h0000) begin
      vout_mv_o <= force_mv_i;
    end else begin
      vout_mv_o <= hs_on_i ? set_mv_i : 16'h0000;
    end
  end
endmodule : ovf_stage_model

// *** ovf_fault_latch_ctrl_test.sv ***
// Self-checking bench for the fault latch control.
// Assumes the checker and stage model are compiled before it.
`timescale 1ns/1ps
module ovf_fault_latch_ctrl_test;
  localparam int HC = 20;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cfg_wr_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [7:0] cfg_wdata_i = 8'h00;
  logic status_clr_i = 1'b0;
  logic turn_on_i = 1'b0;
  logic [15:0] setpoint_mv_i = 16'h03e8;
  logic [1:0] lvl = 2'h0;
  logic [15:0] prebias_mv_i = 16'h0000;
  logic [15:0] force_mv = 16'h0000;
  logic [4:0] fault_raw_i = 5'h00;
  logic ramping_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic [7:0] cfg_rdata_o;
  logic [15:0] vout_mv_i, ov_thresh_mv_o;
  logic hs_on_o, ls_on_o, run_o, ov_error_o;
  logic [5:0] protection_status_o;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  ovf_fault_latch_ctrl #(.HICCUP_CYC(HC)) i_ovf_fault_latch_ctrl (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .status_clr_i(status_clr_i), .turn_on_i(turn_on_i), .setpoint_mv_i(setpoint_mv_i),
    .overvolt_level_field_i(lvl), .vout_mv_i(vout_mv_i), .prebias_mv_i(prebias_mv_i),
    .fault_raw_i(fault_raw_i), .ramping_i(ramping_i), .hs_on_o(hs_on_o), .ls_on_o(ls_on_o),
    .run_o(run_o), .ov_error_o(ov_error_o), .protection_status_o(protection_status_o),
    .ov_thresh_mv_o(ov_thresh_mv_o));
  ovf_stage_model i_ovf_stage_model (.mclk_i(mclk_i), .hs_on_i(hs_on_o), .ls_on_i(ls_on_o),
    .set_mv_i(setpoint_mv_i), .force_mv_i(force_mv), .vout_mv_o(vout_mv_i));
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    cfg_wr_i = 1'b1;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    @(negedge mclk_i);
    cfg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    cfg_addr_i = a;
    @(negedge mclk_i);
    chk({8'h0, cfg_rdata_o}, {8'h0, e});
  endtask : rd
  task automatic wait_run(input logic lv);
    int n;
    n = 0;
    while (run_o !== lv && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    chk({15'h0, run_o}, {15'h0, lv});
  endtask : wait_run
  task automatic t_regs;
    rd(8'h00, 8'h43);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    rd(8'h00, 8'h43);
    clk_en_i = 1'b0;
    wr(8'h00, 8'h00);
    clk_en_i = 1'b1;
    rd(8'h00, 8'h43);
    wr(8'h00, 8'hbc);
    rd(8'h00, 8'hbc);
    wr(8'h00, 8'h43);
    $display("test regs done");
  endtask : t_regs
  task automatic t_thresh;
    logic [15:0] sp [6] = '{16'h0bb8, 16'h0bb8, 16'h03e8, 16'h03e8, 16'h012c, 16'h00c8};
    logic [15:0] ex [6] = '{16'h0ce4, 16'h0e10, 16'h0514, 16'h0514, 16'h0226, 16'h01f4};
    logic [1:0] lv [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
    for (int i = 0; i < 6; i++) begin
      @(negedge mclk_i);
      setpoint_mv_i = sp[i];
      lvl = lv[i];
      repeat (2) @(negedge mclk_i);
      chk(ov_thresh_mv_o, ex[i]);
    end
    setpoint_mv_i = 16'h03e8;
    lvl = 2'h0;
    $display("test thresh done");
  endtask : t_thresh
  task automatic t_ov_latch;
    turn_on_i = 1'b1;
    wait_run(1'b1);
    force_mv = 16'h05dc;
    wait_run(1'b0);
    chk({12'h0, hs_on_o, ls_on_o, ov_error_o, run_o}, 16'h0006);
    chk({10'h0, protection_status_o}, 16'h003d);
    force_mv = 16'h0000;
    repeat (3 * HC) @(negedge mclk_i);
    chk({15'h0, run_o}, 16'h0000);
    status_clr_i = 1'b1;
    @(negedge mclk_i);
    status_clr_i = 1'b0;
    chk({10'h0, protection_status_o}, 16'h003f);
    wait_run(1'b1);
    $display("test ov latch done");
  endtask : t_ov_latch
  task automatic t_prebias;
    prebias_mv_i = 16'h07d0;
    force_mv = 16'h05dc;
    repeat (10) @(negedge mclk_i);
    chk({12'h0, hs_on_o, ls_on_o, ov_error_o, run_o}, 16'h0009);
    force_mv = 16'h0000;
    repeat (5) @(negedge mclk_i);
    prebias_mv_i = 16'h0000;
    $display("test prebias done");
  endtask : t_prebias
  task automatic t_hiccup;
    fault_raw_i = 5'h02;
    wait_run(1'b0);
    chk({10'h0, protection_status_o}, 16'h003b);
    repeat (3 * HC) @(negedge mclk_i);
    chk({15'h0, run_o}, 16'h0000);
    fault_raw_i = 5'h00;
    repeat (HC + 6) @(negedge mclk_i);
    chk({15'h0, run_o}, 16'h0001);
    $display("test hiccup done");
  endtask : t_hiccup
  task automatic t_track;
    status_clr_i = 1'b1;
    @(negedge mclk_i);
    status_clr_i = 1'b0;
    chk({10'h0, protection_status_o}, 16'h003f);
    wr(8'h00, 8'h03);
    ramping_i = 1'b1;
    fault_raw_i = 5'h11;
    repeat (6) @(negedge mclk_i);
    chk({15'h0, run_o}, 16'h0001);
    wr(8'h00, 8'h80);
    wait_run(1'b0);
    chk({10'h0, protection_status_o}, 16'h001f);
    fault_raw_i = 5'h00;
    ramping_i = 1'b0;
    wait_run(1'b1);
    $display("test track done");
  endtask : t_track
  initial begin
    repeat (3) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    t_regs();
    t_thresh();
    t_ov_latch();
    t_prebias();
    t_hiccup();
    t_track();
    test_done();
  end
endmodule : ovf_fault_latch_ctrl_test
bind ovf_fault_latch_ctrl ovf_fault_latch_ctrl_props #(.HICCUP_CYC(HICCUP_CYC)) i_props (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .status_clr_i(status_clr_i),
  .setpoint_mv_i(setpoint_mv_i), .overvolt_level_field_i(overvolt_level_field_i),
  .vout_mv_i(vout_mv_i), .prebias_mv_i(prebias_mv_i), .hs_on_o(hs_on_o), .ls_on_o(ls_on_o),
  .run_o(run_o), .ov_error_o(ov_error_o), .protection_status_o(protection_status_o),
  .ov_thresh_mv_o(ov_thresh_mv_o));
